// ===== bench/qacp_ctrl_model.sv
// Purpose: external controller on the serial configuration port
// Assumes: tasks are entered just after a sys_clk edge
// Notes  : sck period 320 ns, sck idles low outside frames
`timescale 1ns/1ps
module qacp_ctrl_model (
    // serial port pins
    output logic cs_n,
    output logic sck,
    output logic sdi,
    // wire level of the open-drain data output
    input  wire  sdo_level
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        sdi  = 1'b0;
    end
    // n bits msb first, readback taken at each falling edge
    task automatic xfer(input logic [7:0] w, input int n, output logic [7:0] r);
        int i;
        r = 8'h00;
        cs_n = 1'b0;
        #160;
        for (i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #160 sck = 1'b1;
            #160 r = {r[6:0], sdo_level};
            sck = 1'b0;
        end
        #160 cs_n = 1'b1;
        sdi = ~sdi;
    endtask
    // clocking with select high, which the port must ignore
    task automatic noise(input int n);
        repeat (n) begin
            sdi = ~sdi;
            #160 sck = 1'b1;
            #160 sck = 1'b0;
        end
    endtask
endmodule // qacp_ctrl_model

// ===== bench/qacp_top_sva.sv
// Purpose: port assertions for qacp_top
// Assumes: clk_en held high, encode period above 16 cycles
// Notes  : bound from the bench top file
`timescale 1ns/1ps
module qacp_sva (
    // clock and reset
    input wire       sys_clk,
    input wire       reset,
    // pins
    input wire       prog_mode_strap,
    input wire       cs_n_pin,
    input wire       sck_pin,
    input wire       sdi_pin,
    input wire       sdo_pin_in,
    input wire       sdo_pin_out,
    input wire       sdo_pin_oe,
    input wire       sample_clock_pos,
    input wire       sample_clock_neg,
    // results
    input wire [3:0] lane_a,
    input wire [3:0] lane_b,
    input wire       lane_b_enable,
    input wire       low_current,
    input wire       power_down,
    input wire       term_enable,
    input wire       conv_start
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // sequences and checks
    // ------------------------------------------------------------
    sequence par_held(x);
        (prog_mode_strap && $stable(x))[*6];
    endsequence
    sequence enc_rise;
        !power_down && $rose(sample_clock_pos && !sample_clock_neg);
    endsequence
    chk_drain_only: assert property (sdo_pin_out == 1'b0)
        else $error("sdo drives high");
    chk_par_no_drive: assert property (prog_mode_strap[*4] |-> !sdo_pin_oe)
        else $error("sdo pulled in parallel mode");
    chk_par_pd: assert property (par_held(sdi_pin) |-> power_down == sdi_pin)
        else $error("power down not following pin");
    chk_par_current: assert property (par_held(sck_pin) |-> low_current == sck_pin)
        else $error("drive current not following pin");
    chk_par_term: assert property (par_held(sdo_pin_in) |-> term_enable == sdo_pin_in)
        else $error("termination not following pin");
    chk_par_lanes: assert property (par_held({cs_n_pin, sdi_pin}) |->
        lane_b_enable == (!cs_n_pin && !sdi_pin))
        else $error("lane count not following pin");
    chk_ser_idle: assert property ((!prog_mode_strap && cs_n_pin)[*8] |=>
        $stable({low_current, power_down, term_enable, lane_b_enable}))
        else $error("modes changed while deselected");
    chk_pd_quiet: assert property (power_down |-> lane_a == 4'h0 && lane_b == 4'h0)
        else $error("lanes active in power down");
    chk_one_lane: assert property ((!lane_b_enable)[*2] |-> lane_b == 4'h0)
        else $error("second lane active");
    chk_conv_start: assert property (enc_rise |-> ##[1:5] conv_start)
        else $error("no conversion start after encode");
    chk_conv_pulse: assert property (conv_start |=> !conv_start)
        else $error("conversion start too long");
endmodule // qacp_sva

// ===== bench/qacp_top_tb_top.sv
// Purpose: self-checking bench for qacp_top
// Assumes: clk_en held high; strap changed only under reset
// Notes  : serial words watched on channel 0, lane a and, in two-lane modes, lane b
`timescale 1ns/1ps
module qacp_top_tb_top;
    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        strap   = 1'b0;
    logic [3:0]  par     = 4'h0;
    logic        enc     = 1'b0;
    logic [47:0] data    = 48'h0;
    logic [3:0]  ovr     = 4'h0;
    logic [7:0]  rd, m, prev;
    logic [15:0] exp_q[$];
    logic [15:0] word;
    logic        bclk_q  = 1'b0;
    logic        fr_q, fr_m;
    int          tog, nconv, cur_bpl, k;
    int          fail_count = 0;
    int          checked    = 0;
    logic [7:0]  mtab [6] = '{8'h01, 8'h11, 8'h21, 8'h00, 8'h10, 8'h20};
    int          btab [6] = '{16, 14, 12, 8, 7, 6};
    wire         m_cs, m_sck, m_sdi, sdo_out, sdo_oe, sdo_w;
    wire [3:0]   lane_a, lane_b;
    wire         lb_en, fr, bclk, lowc, pd, term, conv;
    wire [3:0]   modes = {term, pd, lowc, lb_en};
    always #20 sys_clk = ~sys_clk;
    // pull-up on sdo; parallel pins are {term, cs, sck, sdi}
    assign sdo_w = sdo_oe ? 1'b0 : (strap ? par[3] : 1'b1);
    qacp_ctrl_model ctl (.cs_n(m_cs), .sck(m_sck), .sdi(m_sdi), .sdo_level(sdo_w));
    qacp_top dut_u (
        .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
        .prog_mode_strap(strap), .cs_n_pin(strap ? par[2] : m_cs),
        .sck_pin(strap ? par[1] : m_sck), .sdi_pin(strap ? par[0] : m_sdi),
        .sdo_pin_in(sdo_w), .sdo_pin_out(sdo_out), .sdo_pin_oe(sdo_oe),
        .sample_clock_pos(enc), .sample_clock_neg(~enc),
        .sample_data(data), .sample_overrange(ovr),
        .lane_a(lane_a), .lane_b(lane_b), .lane_b_enable(lb_en),
        .frame_start_out(fr), .bit_clock_out(bclk), .low_current(lowc),
        .power_down(pd), .term_enable(term), .conv_start(conv));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cmp16(input logic [15:0] e, input logic [15:0] a);
        checked++;
        if (a !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic post(input logic [15:0] a);
        if (exp_q.size() > 0)
            cmp16(exp_q.pop_front(), a);
        else begin
            checked++;
            fail_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, ~a, a);
        end
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] a);
        exp_q.push_back(e);
        post(a);
    endtask
    function automatic logic [15:0] mexp(input logic [7:0] v);
        return {12'h0, v[3], v[2], v[1], ~v[0] & ~v[2]};
    endfunction
    task automatic test_done;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // encode train; frames 1 to 4 of each run are judged
    task automatic enc_run(input logic [7:0] v, input int bpl);
        int c;
        int s;
        logic [15:0] w;
        ctl.xfer(v, 8, rd);
        tick(6);
        cur_bpl = bpl;
        nconv = 0;
        for (c = 0; c < 6; c++) begin
            data = {16'($urandom), $urandom};
            ovr = 4'($urandom);
            w = v[5] ? {data[11:0], 4'h0} : {data[11:0], {2{ovr[0]}}, 2'b00};
            s = v[0] ? 16 - bpl : 16 - 2 * bpl;
            if (c > 0 && c < 5) begin
                exp_q.push_back(w >> s);
                exp_q.push_back({v == 8'h10, 7'h0, 8'(bpl)});
            end
            tick(1);
            enc = 1'b1;
            tick(20);
            enc = 1'b0;
            tick(19);
        end
    endtask
    // watcher: rebuilds channel 0 words and tick counts per frame;
    // samples on the falling edge, away from the launching edge
    always @(negedge sys_clk) begin
        if (bclk !== bclk_q) begin
            tog++;
            if (tog < cur_bpl)
                word = (lb_en === 1'b1) ? {word[13:0], lane_a[0], lane_b[0]}
                                        : {word[14:0], lane_a[0]};
            if (tog == 1)
                fr_m = fr;
        end
        bclk_q = bclk;
        if (conv === 1'b1) begin
            nconv++;
            if (nconv >= 3)
                post(word);
            if (nconv >= 3)
                post({fr_m ^ fr_q, 7'h0, 8'(tog)});
            fr_q = fr_m;
            tog = 0;
            word = (lb_en === 1'b1) ? {14'h0, lane_a[0], lane_b[0]}
                                    : {15'h0, lane_a[0]};
        end
    end
    initial begin
        #1000000;
        fail_count++;
        test_done();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        prev = 8'h00;
        k = $urandom(32'hB0574340);
        tick(6);
        reset = 1'b0;
        for (k = 0; k < 8; k++) begin
            m = (k == 0) ? 8'hFF : 8'($urandom);
            ctl.xfer(m, 8, rd);
            chk({8'h0, prev}, {8'h0, rd});
            tick(6);
            chk(mexp(m), {12'h0, modes});
            prev = m;
        end
        ctl.xfer(8'h5A, 5, rd);
        tick(6);
        chk({11'h0, prev[7:3]}, {11'h0, rd[4:0]});
        ctl.noise(12);
        tick(6);
        chk(mexp(prev), {12'h0, modes});
        ctl.xfer(prev, 8, rd);
        chk({8'h0, prev}, {8'h0, rd});
        $display("serial port test done");
        reset = 1'b1;
        strap = 1'b1;
        tick(2);
        reset = 1'b0;
        for (k = 0; k < 16; k++) begin
            par = 4'(k);
            tick(8);
            m = {4'h0, par[3], par[0], par[1], par[2]};
            chk(mexp(m), {12'h0, modes});
        end
        $display("parallel pin test done");
        reset = 1'b1;
        strap = 1'b0;
        tick(2);
        reset = 1'b0;
        for (k = 0; k < 6; k++)
            enc_run(mtab[k], btab[k]);
        $display("serializer test done");
        test_done();
    end
endmodule // qacp_top_tb_top
bind qacp_top qacp_sva chk_u (
    .sys_clk(sys_clk), .reset(reset), .prog_mode_strap(prog_mode_strap),
    .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin),
    .sdo_pin_in(sdo_pin_in), .sdo_pin_out(sdo_pin_out), .sdo_pin_oe(sdo_pin_oe),
    .sample_clock_pos(sample_clock_pos), .sample_clock_neg(sample_clock_neg),
    .lane_a(lane_a), .lane_b(lane_b), .lane_b_enable(lane_b_enable),
    .low_current(low_current), .power_down(power_down),
    .term_enable(term_enable), .conv_start(conv_start));

// ===== hdl/qacp_defines.vh
// Purpose : constants for the quad converter configuration and output port
// Assumes : included by qacp_top.v only
// Notes   : mode register layout and serializer figures
`ifndef QACP_DEFINES_VH
`define QACP_DEFINES_VH

// ---------------------------------------------------------------
// mode control register
// ---------------------------------------------------------------
`define QACP_MODE_W          8
`define QACP_MODE_RESET      8'h00
`define QACP_BIT_ONE_LANE    0
`define QACP_BIT_LOW_CURRENT 1
`define QACP_BIT_POWER_DOWN  2
`define QACP_BIT_TERM_EN     3
`define QACP_SER_LSB         4
`define QACP_SER_MSB         5

// ---------------------------------------------------------------
// serialization codes
// ---------------------------------------------------------------
`define QACP_SER_16          2'h0
`define QACP_SER_14          2'h1
`define QACP_SER_12          2'h2
`define QACP_SER_PARALLEL    2'h0

// ---------------------------------------------------------------
// bits per lane for each format
// ---------------------------------------------------------------
`define QACP_BPL_2L_16       5'h08
`define QACP_BPL_2L_14       5'h07
`define QACP_BPL_2L_12       5'h06
`define QACP_BPL_1L_16       5'h10
`define QACP_BPL_1L_14       5'h0E
`define QACP_BPL_1L_12       5'h0C

// ---------------------------------------------------------------
// word layout
// ---------------------------------------------------------------
`define QACP_DATA_W          12
`define QACP_WORD_W          16
`define QACP_CHANNELS        4

// ---------------------------------------------------------------
// pin synchroniser start value: select and encode complement idle high
// ---------------------------------------------------------------
`define QACP_SYNC_IDLE       7'h42

`endif

// ===== hdl/qacp_top.v
// Purpose : configuration port and serial output framing of a four-channel
//           sampling converter
// Assumes : all pins are asynchronous to sys_clk and pass two flip-flops;
//           the encode period spans at least 17 sys_clk cycles
// Notes   : bit_tick pulses are spread over the measured encode period by a
//           fractional accumulator
`timescale 1ns/1ps
`include "qacp_defines.vh"

// Overview of operation
// - serial mode shifts data in on serial clock only while select is low
// - data input bits are captured on rising serial clock edges
// - readback drives register bits out, changing after falling clock edges
// - data output only pulls low; high comes from external pull-up
// - parallel mode: select pin level picks two-lane or one-lane output
// - parallel mode: serial clock pin level picks output drive current
// - parallel mode: data input pin level powers down the converter
// - parallel mode: data output pin is input enabling output termination
// - conversion of all channels starts on each rising encode edge outside power down
// - padding bits are zero whenever the sample is not overranged
// - two-lane 14-bit mode: frame period is two encode cycles
// - one-lane modes disable second lane, all bits on first lane
// - bit period is sample period divided by bits per lane
// - two-lane emits two bits per bit period, one-lane emits one
module qacp_top #(
    parameter MODE_W = `QACP_MODE_W,
    parameter CNT_W  = 16
) (
    // clock, reset, enable
    input  wire                     sys_clk,
    input  wire                     reset,
    input  wire                     clk_en,
    // strap and configuration pins
    input  wire                     prog_mode_strap,
    input  wire                     cs_n_pin,
    input  wire                     sck_pin,
    input  wire                     sdi_pin,
    input  wire                     sdo_pin_in,
    output wire                     sdo_pin_out,
    output reg                      sdo_pin_oe,
    // encode inputs
    input  wire                     sample_clock_pos,
    input  wire                     sample_clock_neg,
    // converter core results
    input  wire [4*12-1:0]          sample_data,
    input  wire [3:0]               sample_overrange,
    // serial outputs
    output wire [3:0]               lane_a,
    output wire [3:0]               lane_b,
    output reg                      lane_b_enable,
    output reg                      frame_start_out,
    output reg                      bit_clock_out,
    // decoded operating modes and conversion start
    output reg                      low_current,
    output reg                      power_down,
    output reg                      term_enable,
    output reg                      conv_start
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    reg  [6:0]          sync1;
    reg  [6:0]          sync2;
    reg  [6:0]          sync3;
    wire                strap_s;
    wire                cs_n_s;
    wire                sck_s;
    wire                sdi_s;
    wire                sdo_in_s;
    wire                enc_s;
    wire                sck_rise;
    wire                sck_fall;
    wire                cs_fall;
    wire                cs_rise;
    wire                enc_rise;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            // start at the pins' idle levels so no false edge follows reset
            sync1 <= `QACP_SYNC_IDLE;
            sync2 <= `QACP_SYNC_IDLE;
            sync3 <= `QACP_SYNC_IDLE;
        end else if (clk_en) begin
            sync1 <= {sample_clock_neg, sample_clock_pos, sdo_pin_in,
                      sdi_pin, sck_pin, cs_n_pin, prog_mode_strap};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign strap_s  = sync2[0];
    assign cs_n_s   = sync2[1];
    assign sck_s    = sync2[2];
    assign sdi_s    = sync2[3];
    assign sdo_in_s = sync2[4];
    // differential encode: positive rises as its complement falls
    assign enc_s    = sync2[5] & ~sync2[6];
    assign sck_rise = sck_s & ~sync3[2];
    assign sck_fall = ~sck_s & sync3[2];
    assign cs_fall  = ~cs_n_s & sync3[1];
    assign cs_rise  = cs_n_s & ~sync3[1];
    assign enc_rise = enc_s & ~(sync3[5] & ~sync3[6]);

    // ---------------------------------------------------------------
    // serial programming port
    // ---------------------------------------------------------------
    reg  [MODE_W-1:0]   mode_reg;
    reg  [MODE_W-1:0]   wr_sh;
    reg  [MODE_W-1:0]   rb_sh;
    reg  [4:0]          wr_cnt;
    wire                ser_active;

    assign ser_active = ~strap_s & ~cs_n_s;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mode_reg <= `QACP_MODE_RESET;
            wr_sh    <= {MODE_W{1'b0}};
            rb_sh    <= {MODE_W{1'b0}};
            wr_cnt   <= 5'h00;
        end else if (clk_en) begin
            if (~strap_s && cs_fall) begin
                rb_sh  <= mode_reg;
                wr_cnt <= 5'h00;
            end else if (ser_active) begin
                if (sck_rise) begin
                    wr_sh <= {wr_sh[MODE_W-2:0], sdi_s};
                    if (wr_cnt != 5'h1F)
                        wr_cnt <= wr_cnt + 5'h01;
                end
                if (sck_fall)
                    rb_sh <= {rb_sh[MODE_W-2:0], 1'b0};
            end
            // commit a complete word when select returns high
            if (~strap_s && cs_rise && wr_cnt >= MODE_W[4:0])
                mode_reg <= wr_sh;
        end
    end

    // open drain: never drives high
    assign sdo_pin_out = 1'b0;

    always @(posedge sys_clk or posedge reset) begin
        if (reset)
            sdo_pin_oe <= 1'b0;
        else if (clk_en)
            sdo_pin_oe <= ser_active & ~rb_sh[MODE_W-1];
    end

    // ---------------------------------------------------------------
    // operating mode selection
    // ---------------------------------------------------------------
    reg                 one_lane;
    reg  [1:0]          ser_fmt;
    reg  [4:0]          bpl;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            one_lane    <= 1'b0;
            ser_fmt     <= `QACP_SER_16;
            low_current <= 1'b0;
            power_down  <= 1'b0;
            term_enable <= 1'b0;
        end else if (clk_en) begin
            if (strap_s) begin
                one_lane    <= cs_n_s;
                low_current <= sck_s;
                power_down  <= sdi_s;
                term_enable <= sdo_in_s;
                ser_fmt     <= `QACP_SER_PARALLEL;
            end else begin
                one_lane    <= mode_reg[`QACP_BIT_ONE_LANE];
                low_current <= mode_reg[`QACP_BIT_LOW_CURRENT];
                power_down  <= mode_reg[`QACP_BIT_POWER_DOWN];
                term_enable <= mode_reg[`QACP_BIT_TERM_EN];
                ser_fmt     <= mode_reg[`QACP_SER_MSB:`QACP_SER_LSB];
            end
        end
    end

    always @* begin
        case (ser_fmt)
            `QACP_SER_14: bpl = one_lane ? `QACP_BPL_1L_14 : `QACP_BPL_2L_14;
            `QACP_SER_12: bpl = one_lane ? `QACP_BPL_1L_12 : `QACP_BPL_2L_12;
            default:      bpl = one_lane ? `QACP_BPL_1L_16 : `QACP_BPL_2L_16;
        endcase
    end

    // ---------------------------------------------------------------
    // encode period measurement and bit tick
    // ---------------------------------------------------------------
    reg  [CNT_W-1:0]    period_cnt;
    reg  [CNT_W-1:0]    period_meas;
    reg  [CNT_W-1:0]    acc;
    reg  [4:0]          tick_cnt;
    wire [CNT_W-1:0]    acc_sum;
    wire                bit_tick;

    assign acc_sum  = acc + {{(CNT_W-5){1'b0}}, bpl};
    // spreads exactly bpl ticks over one measured encode period
    assign bit_tick = (period_meas != {CNT_W{1'b0}}) &&
                      (acc_sum >= period_meas) && (tick_cnt < bpl);

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            period_cnt  <= {CNT_W{1'b0}};
            period_meas <= {CNT_W{1'b0}};
            acc         <= {CNT_W{1'b0}};
            tick_cnt    <= 5'h00;
        end else if (clk_en) begin
            if (enc_rise) begin
                period_meas <= period_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
                period_cnt  <= {CNT_W{1'b0}};
                acc         <= {CNT_W{1'b0}};
                tick_cnt    <= 5'h00;
            end else begin
                if (period_cnt != {CNT_W{1'b1}})
                    period_cnt <= period_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
                if (bit_tick) begin
                    acc      <= acc_sum - period_meas;
                    tick_cnt <= tick_cnt + 5'h01;
                end else begin
                    acc      <= acc_sum;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // per-channel serializers
    // ---------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `QACP_CHANNELS; ch = ch + 1) begin : g_ch
            reg  [`QACP_WORD_W-1:0] sh;
            wire [`QACP_DATA_W-1:0] d;
            wire                    pad;

            assign d   = sample_data[ch*`QACP_DATA_W +: `QACP_DATA_W];
            // padding is zero unless the sample overranged
            assign pad = sample_overrange[ch];

            always @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    sh <= {`QACP_WORD_W{1'b0}};
                end else if (clk_en) begin
                    if (enc_rise) begin
                        case (ser_fmt)
                            `QACP_SER_14: sh <= {d, pad, pad, 2'h0};
                            `QACP_SER_12: sh <= {d, 4'h0};
                            default:      sh <= {d, pad, pad, 2'h0};
                        endcase
                    end else if (bit_tick) begin
                        if (one_lane)
                            sh <= {sh[`QACP_WORD_W-2:0], 1'b0};
                        else
                            sh <= {sh[`QACP_WORD_W-3:0], 2'h0};
                    end
                end
            end

            assign lane_a[ch] = ~power_down & sh[`QACP_WORD_W-1];
            assign lane_b[ch] = ~power_down & ~one_lane &
                                sh[`QACP_WORD_W-2];
        end
    endgenerate

    // ---------------------------------------------------------------
    // frame, bit clock and conversion start
    // ---------------------------------------------------------------
    reg                 pair_phase;
    wire                two_sample_frame;
    wire [4:0]          half_bpl;

    assign two_sample_frame = ~one_lane && (ser_fmt == `QACP_SER_14);
    assign half_bpl         = {1'b0, bpl[4:1]};

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pair_phase      <= 1'b0;
            frame_start_out <= 1'b0;
            bit_clock_out   <= 1'b0;
            lane_b_enable   <= 1'b0;
            conv_start      <= 1'b0;
        end else if (clk_en) begin
            conv_start    <= enc_rise & ~power_down;
            lane_b_enable <= ~one_lane & ~power_down;
            if (enc_rise)
                pair_phase <= two_sample_frame ? ~pair_phase : 1'b0;
            if (power_down) begin
                frame_start_out <= 1'b0;
                bit_clock_out   <= 1'b0;
            end else begin
                if (bit_tick)
                    bit_clock_out <= ~bit_clock_out;
                if (two_sample_frame)
                    frame_start_out <= ~pair_phase;
                else
                    frame_start_out <= (tick_cnt < half_bpl);
            end
        end
    end

endmodule // qacp_top
